/* File: hw/ncu_top.sv */
// Number conversion unit: accumulator conversions and table conversions.
// Assumes an APB master on core_clk; data memory lives in ncu_mem.
//
// Our own choices: the APB slave port and the register addresses.
`timescale 1ns/100ps
module ncu_top #(
	parameter int AW = 8
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic zero_result_flag,
	output logic negative_result_flag,
	output logic operand_overflow_flag,
	output logic invalid_decimal_flag,
	output logic busy
);
	import ncu_pkg::*;

	// ****************************************
	// Conversion functions
	// ****************************************
	function automatic logic [32:0] bcd_to_bin(input logic [31:0] a);
		logic [31:0] r;
		logic bad;
		r = '0;
		bad = 1'b0;
		for (int i = 7; i >= 0; i--) begin
			if (a[4*i+:4] > HEX_NINE) begin
				bad = 1'b1;
			end
			r = r * 32'd10 + {28'h0, a[4*i+:4]};
		end
		return {bad, r};
	endfunction

	function automatic logic [31:0] bin_to_bcd(input logic [31:0] b);
		logic [39:0] d;
		d = '0;
		for (int i = 31; i >= 0; i--) begin
			for (int j = 0; j < 10; j++) begin
				if (d[4*j+:4] > 4'h4) begin
					d[4*j+:4] = d[4*j+:4] + 4'h3;
				end
			end
			d = {d[38:0], b[i]};
		end
		// Values above 99999999 lose their top digits
		return d[31:0];
	endfunction

	function automatic logic [3:0] asc_to_hex(input logic [7:0] c);
		if (c[7:4] == ASC_DIG_HI && c[3:0] <= HEX_NINE) begin
			return c[3:0];
		end else if (c[7:4] == ASC_LET_HI && c[3:0] >= 4'h1 &&
			c[3:0] <= 4'h6) begin
			return c[3:0] + HEX_NINE;
		end
		// Illegal characters pack as digit zero
		return 4'h0;
	endfunction

	function automatic logic [7:0] hex_to_asc(input logic [3:0] d);
		if (d <= HEX_NINE) begin
			return {ASC_DIG_HI, d};
		end
		return {ASC_LET_HI, d - HEX_NINE};
	endfunction

	function automatic logic is_mapped(input logic [7:0] a);
		return a == OFF_ACC || a == OFF_STACK || a == OFF_OPND ||
			a == OFF_CMD || a == OFF_STATUS || a == OFF_MADDR ||
			a == OFF_MDATA;
	endfunction

	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		ncu_state_e st;
		logic [31:0] acc;
		logic [31:0] stk;
		logic [31:0] opnd;
		logic [AW-1:0] madr;
		logic zf;
		logic nf;
		logic of;
		logic bf;
		logic [2:0] op;
		logic [AW-1:0] src;
		logic [AW-1:0] dst;
		logic [31:0] rem;
		logic ph;
		logic [15:0] hold;
		logic pready;
		logic [1:0] stg;
		logic [31:0] prdata;
		logic men;
		logic mwe;
		logic [AW-1:0] maddr;
		logic [15:0] mwd;
	} ncu_regs_s;

	localparam logic [33:0] DEPTH = 34'(1 << AW);

	ncu_regs_s r_reg;
	ncu_regs_s r_next;
	logic [15:0] mem_rdata;
	logic [32:0] bin_res;
	logic [31:0] bcd_res;
	logic [15:0] gray_bin;
	logic [31:0] gray_res;
	logic [33:0] src_end;
	logic [33:0] dst_end;
	logic tbl_ovf;
	logic acc_phase;
	logic take;
	logic cmd_take;
	logic [2:0] cmd_op;

	assign bin_res = bcd_to_bin(r_reg.acc);
	assign bcd_res = bin_to_bcd(r_reg.acc);

	// Gray decode: each binary bit is the XOR of its own Gray bit and all higher Gray bits
	generate
		for (genvar g = 0; g < GRAY_W; g++) begin : g_gray
			assign gray_bin[g] = ^r_reg.acc[GRAY_W-1:g];
		end
	endgenerate
	logic [31:0] gray_bcd;
	assign gray_bcd = bin_to_bcd({16'h0, gray_bin});
	// low 10 bits kept, upper 22 forced to zero
	assign gray_res = {22'h0, gray_bcd[GRAY_KEEP-1:0]};

	// table must fit in data memory
	assign src_end = {2'b00, r_reg.acc} + {2'b00, r_reg.stk};
	assign dst_end = {2'b00, r_reg.opnd} + ((cmd_op == OP_C2H) ?
		({2'b00, r_reg.stk} + 34'h1) >> 1 : {1'b0, r_reg.stk, 1'b0});
	assign tbl_ovf = src_end > DEPTH || dst_end > DEPTH;

	assign acc_phase = psel && penable && !r_reg.pready;
	assign take = psel && penable && r_reg.pready;
	assign cmd_take = take && pwrite && paddr == OFF_CMD;
	assign cmd_op = pwdata[2:0];

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		r_next = r_reg;
		r_next.men = 1'b0;
		r_next.mwe = 1'b0;
		r_next.pready = 1'b0;
		if (acc_phase) begin
			// Everything but status waits while a table runs
			if (r_reg.st != S_IDLE && paddr != OFF_STATUS) begin
				r_next.pready = 1'b0;
			end else if (!pwrite && paddr == OFF_MDATA) begin
				case (r_reg.stg)
					2'd0: begin
						r_next.men = 1'b1;
						r_next.maddr = r_reg.madr;
						r_next.stg = 2'd1;
					end
					2'd1: r_next.stg = 2'd2;
					default: begin
						r_next.prdata = {16'h0, mem_rdata};
						r_next.pready = 1'b1;
						r_next.stg = 2'd0;
					end
				endcase
			end else begin
				r_next.pready = 1'b1;
				case (paddr)
					OFF_ACC: r_next.prdata = r_reg.acc;
					OFF_STACK: r_next.prdata = r_reg.stk;
					OFF_OPND: r_next.prdata = r_reg.opnd;
					OFF_MADDR: r_next.prdata = 32'(r_reg.madr);
					OFF_STATUS: begin
						r_next.prdata = RST_WORD;
						r_next.prdata[ST_ZERO_BIT] = r_reg.zf;
						r_next.prdata[ST_NEG_BIT] = r_reg.nf;
						r_next.prdata[ST_OVF_BIT] = r_reg.of;
						r_next.prdata[ST_BCD_BIT] = r_reg.bf;
						r_next.prdata[ST_BUSY_BIT] = r_reg.st != S_IDLE;
					end
					default: r_next.prdata = RST_WORD;
				endcase
			end
		end
		if (take && pwrite) begin
			case (paddr)
				OFF_ACC: r_next.acc = pwdata;
				OFF_STACK: r_next.stk = pwdata;
				OFF_OPND: r_next.opnd = pwdata;
				OFF_MADDR: r_next.madr = pwdata[AW-1:0];
				OFF_MDATA: begin
					r_next.men = 1'b1;
					r_next.mwe = 1'b1;
					r_next.maddr = r_reg.madr;
					r_next.mwd = pwdata[15:0];
				end
				default: ;
			endcase
		end
		if (cmd_take) begin
			case (cmd_op)
				OP_BIN: begin
					r_next.acc = bin_res[31:0];
					r_next.bf = bin_res[32];
				end
				OP_BCD: r_next.acc = bcd_res;
				OP_CPL: r_next.acc = ~r_reg.acc;
				OP_GRAY: r_next.acc = gray_res;
				OP_C2H, OP_H2C: begin
					r_next.of = tbl_ovf;
					r_next.op = cmd_op;
					r_next.src = r_reg.acc[AW-1:0];
					r_next.dst = r_reg.opnd[AW-1:0];
					r_next.rem = r_reg.stk;
					r_next.ph = 1'b0;
					r_next.hold = RST_HALF;
					if (!tbl_ovf && r_reg.stk != RST_WORD) begin
						r_next.st = S_RD;
					end
				end
				default: ;
			endcase
			if (cmd_op >= OP_BIN && cmd_op <= OP_GRAY) begin
				r_next.zf = r_next.acc == RST_WORD;
				r_next.nf = r_next.acc[31];
			end
		end
		// table ops touch only the overflow flag
		case (r_reg.st)
			S_IDLE: ;
			S_RD: begin
				r_next.men = 1'b1;
				r_next.maddr = r_reg.src;
				r_next.src = r_reg.src + 1'b1;
				r_next.st = S_W1;
			end
			S_W1: r_next.st = S_GET;
			S_GET: begin
				r_next.rem = r_reg.rem - 32'h1;
				if (r_reg.op == OP_C2H) begin
					r_next.hold = {r_reg.hold[7:0],
						asc_to_hex(mem_rdata[15:8]),
						asc_to_hex(mem_rdata[7:0])};
					r_next.ph = !r_reg.ph;
					r_next.st = (r_reg.ph || r_reg.rem == 32'h1) ?
						S_WR : S_RD;
				end else begin
					r_next.hold = mem_rdata;
					r_next.ph = 1'b0;
					r_next.st = S_WR;
				end
			end
			S_WR: begin
				r_next.men = 1'b1;
				r_next.mwe = 1'b1;
				r_next.maddr = r_reg.dst;
				r_next.dst = r_reg.dst + 1'b1;
				if (r_reg.op == OP_C2H) begin
					r_next.mwd = r_reg.hold;
					r_next.hold = RST_HALF;
					r_next.ph = 1'b0;
					r_next.st = (r_reg.rem == RST_WORD) ? S_IDLE : S_RD;
				end else begin
					r_next.mwd = r_reg.ph ?
						{hex_to_asc(r_reg.hold[7:4]),
						hex_to_asc(r_reg.hold[3:0])} :
						{hex_to_asc(r_reg.hold[15:12]),
						hex_to_asc(r_reg.hold[11:8])};
					r_next.ph = !r_reg.ph;
					if (r_reg.ph) begin
						r_next.st = (r_reg.rem == RST_WORD) ? S_IDLE : S_RD;
					end
				end
			end
			default: r_next.st = S_IDLE;
		endcase
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			r_reg <= '0;
		end else begin
			r_reg <= r_next;
		end
	end

	ncu_mem #(.DW(16), .AW(AW)) u_mem (
		.core_clk(core_clk),
		.rst(rst),
		.en(r_reg.men),
		.we(r_reg.mwe),
		.addr(r_reg.maddr),
		.wdata(r_reg.mwd),
		.rdata(mem_rdata)
	);

	assign prdata = r_reg.prdata;
	assign pready = r_reg.pready;
	assign pslverr = take && !is_mapped(paddr);
	assign zero_result_flag = r_reg.zf;
	assign negative_result_flag = r_reg.nf;
	assign operand_overflow_flag = r_reg.of;
	assign invalid_decimal_flag = r_reg.bf;
	assign busy = r_reg.st != S_IDLE;

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	logic acc_cmd;
	logic bad_digit;
	logic [3:0] acc_low;
	logic [3:0] acc_mod10;
	assign acc_cmd = cmd_take && cmd_op >= OP_BIN && cmd_op <= OP_GRAY;
	// Reference values built apart from the conversion functions
	assign bad_digit = |(r_reg.acc[31:3] & (r_reg.acc[30:2] |
		r_reg.acc[29:1]) & 29'h1111_1111);
	assign acc_low = r_reg.acc[3:0];
	assign acc_mod10 = 4'(r_reg.acc % 32'd10);

	property p_bin;
		cmd_take && cmd_op == OP_BIN && acc_low <= HEX_NINE
			|=> acc_mod10 == $past(acc_low);
	endproperty
	a_bin: assert property (p_bin) else $error("bin result wrong");

	property p_badbcd;
		cmd_take && cmd_op == OP_BIN |=> r_reg.bf == $past(bad_digit);
	endproperty
	a_badbcd: assert property (p_badbcd) else $error("bcd flag");

	property p_zero;
		acc_cmd |=> r_reg.zf == (r_reg.acc == RST_WORD);
	endproperty
	a_zero: assert property (p_zero) else $error("zero flag");

	property p_neg;
		acc_cmd |=> r_reg.nf == r_reg.acc[31];
	endproperty
	a_neg: assert property (p_neg) else $error("neg flag");

	property p_bcd;
		cmd_take && cmd_op == OP_BCD |=> acc_low == $past(acc_mod10);
	endproperty
	a_bcd: assert property (p_bcd) else $error("bcd result wrong");

	property p_cpl;
		cmd_take && cmd_op == OP_CPL |=> r_reg.acc == ~$past(r_reg.acc);
	endproperty
	a_cpl: assert property (p_cpl) else $error("invert wrong");

	property p_gray;
		cmd_take && cmd_op == OP_GRAY |=> r_reg.acc[31:GRAY_KEEP] == '0;
	endproperty
	a_gray: assert property (p_gray) else $error("gray upper bits");

	property p_ovf;
		cmd_take && (cmd_op == OP_C2H || cmd_op == OP_H2C) && tbl_ovf
			|=> (r_reg.of && !busy) [*2];
	endproperty
	a_ovf: assert property (p_ovf) else $error("overflow refuse");

	property p_keep;
		cmd_take && cmd_op == OP_C2H |=> $stable(r_reg.zf) &&
			$stable(r_reg.nf) && $stable(r_reg.bf);
	endproperty
	a_keep: assert property (p_keep) else $error("flag disturbed");

	property p_run;
		cmd_take && cmd_op == OP_H2C && !tbl_ovf && r_reg.stk != RST_WORD
			|=> busy [*5] ##1 r_reg.men && r_reg.mwe;
	endproperty
	a_run: assert property (p_run) else $error("hta no write");

	c_bin: cover property (cmd_take && cmd_op == OP_BIN && bin_res[32]);
	c_c2h: cover property (busy && r_reg.op == OP_C2H ##1 !busy);
	c_h2c: cover property (busy && r_reg.op == OP_H2C ##1 !busy);
	c_err: cover property (pslverr);
endmodule // ncu_top

/* File: inc/ncu_pkg.sv */
// Constants, op codes and state encoding of the number conversion unit.
// Assumes a 32-bit APB master and one 100 MHz clock.
package ncu_pkg;
	// ****************************************
	// Register offsets (byte addresses)
	// ****************************************
	localparam logic [7:0] OFF_ACC = 8'h00;
	localparam logic [7:0] OFF_STACK = 8'h04;
	localparam logic [7:0] OFF_OPND = 8'h08;
	localparam logic [7:0] OFF_CMD = 8'h0C;
	localparam logic [7:0] OFF_STATUS = 8'h10;
	localparam logic [7:0] OFF_MADDR = 8'h14;
	localparam logic [7:0] OFF_MDATA = 8'h18;

	// ****************************************
	// Status fields and reset values
	// ****************************************
	localparam int ST_ZERO_BIT = 0;
	localparam int ST_NEG_BIT = 1;
	localparam int ST_OVF_BIT = 2;
	localparam int ST_BCD_BIT = 3;
	localparam int ST_BUSY_BIT = 8;
	localparam logic [31:0] RST_WORD = 32'h0000_0000;
	localparam logic [15:0] RST_HALF = 16'h0000;

	// ****************************************
	// Operations and character codes
	// ****************************************
	localparam logic [2:0] OP_NONE = 3'h0;
	localparam logic [2:0] OP_BIN = 3'h1;
	localparam logic [2:0] OP_BCD = 3'h2;
	localparam logic [2:0] OP_CPL = 3'h3;
	localparam logic [2:0] OP_GRAY = 3'h4;
	localparam logic [2:0] OP_C2H = 3'h5;
	localparam logic [2:0] OP_H2C = 3'h6;
	localparam logic [3:0] ASC_DIG_HI = 4'h3;
	localparam logic [3:0] ASC_LET_HI = 4'h4;
	localparam logic [3:0] HEX_NINE = 4'h9;
	localparam int GRAY_W = 16;
	localparam int GRAY_KEEP = 10;

	// ****************************************
	// Table sequencer states, Gray coded
	// ****************************************
	typedef enum logic [2:0] {
		S_IDLE = 3'b000,
		S_RD = 3'b001,
		S_W1 = 3'b011,
		S_GET = 3'b010,
		S_WR = 3'b110
	} ncu_state_e;
endpackage

/* File: hw/ncu_mem.sv */
// Data memory of the conversion unit: one port, registered read data.
// Assumes the caller holds en for one cycle per access.
`timescale 1ns/100ps
module ncu_mem #(
	parameter int DW = 16,
	parameter int AW = 8
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic en,
	input wire logic we,
	input wire logic [AW-1:0] addr,
	input wire logic [DW-1:0] wdata,
	output logic [DW-1:0] rdata
);
	logic [DW-1:0] mem [0:(1<<AW)-1];

	// Array has no reset, like any real RAM macro
	always_ff @(posedge core_clk) begin
		if (en && we) begin
			mem[addr] <= wdata;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			rdata <= '0;
		end else if (en && !we) begin
			rdata <= mem[addr];
		end
	end
endmodule // ncu_mem

/* File: bench/ncu_top_tb.sv */
// Self-checking bench of the number conversion unit, driven over APB.
// Assumes ncu_top with default memory size; its assertions live inside it.
`timescale 1ns/100ps
module ncu_top_tb;
	import ncu_pkg::*;
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic pready, pslverr, busy;
	logic zero_result_flag, negative_result_flag;
	logic operand_overflow_flag, invalid_decimal_flag;
	int n_errors = 0;
	int cmp_count = 0;
	logic [31:0] seed = 32'h0000_0003;
	logic [31:0] rd, v;
	logic last_err;
	logic [2:0] op;
	logic [3:0] dg [0:15];

	always #5 core_clk = ~core_clk;

	ncu_top ncu_top_inst (
		.core_clk(core_clk),
		.rst(rst),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.zero_result_flag(zero_result_flag),
		.negative_result_flag(negative_result_flag),
		.operand_overflow_flag(operand_overflow_flag),
		.invalid_decimal_flag(invalid_decimal_flag),
		.busy(busy)
	);

	// ****************************************
	// Reference functions
	// ****************************************
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	function automatic logic [31:0] bcd2bin(input logic [31:0] x);
		logic [31:0] r;
		r = 32'h0000_0000;
		for (int i = 7; i >= 0; i--) r = r * 10 + x[i*4 +: 4];
		return r;
	endfunction

	// Only eight digits fit, so higher decades drop out
	function automatic logic [31:0] bin2bcd(input logic [31:0] x);
		logic [31:0] r;
		for (int i = 0; i < 8; i++) begin
			r[i*4 +: 4] = 4'(x % 10);
			x = x / 10;
		end
		return r;
	endfunction

	function automatic logic [31:0] gray_exp(input logic [15:0] g);
		logic [15:0] b;
		b[15] = g[15];
		for (int i = 14; i >= 0; i--) b[i] = b[i+1] ^ g[i];
		return bin2bcd({16'h0000, b}) & 32'h0000_03FF;
	endfunction

	function automatic logic nonbcd(input logic [31:0] x);
		logic r;
		r = 1'b0;
		for (int i = 0; i < 8; i++) if (x[i*4 +: 4] > 4'h9) r = 1'b1;
		return r;
	endfunction

	function automatic logic [7:0] chr(input logic [3:0] d);
		return (d > 4'h9) ? 8'h37 + 8'(d) : 8'h30 + 8'(d);
	endfunction

	// ****************************************
	// Bus and check tasks
	// ****************************************
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Request held until pready is seen high at a rising edge
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		@(posedge core_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (pready !== 1'b1 && n < 2000);
		if (n >= 2000) n_errors++;
		rd = prdata;
		last_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic mem_wr(input logic [7:0] a, input logic [15:0] d);
		apb(1'b1, OFF_MADDR, {24'h0, a});
		apb(1'b1, OFF_MDATA, {16'h0, d});
	endtask

	task automatic mem_rd(input logic [7:0] a);
		apb(1'b1, OFF_MADDR, {24'h0, a});
		apb(1'b0, OFF_MDATA, 32'h0);
	endtask

	task automatic acc_op(input logic [2:0] o, input logic [31:0] x);
		logic [31:0] e;
		logic bad;
		bad = (o == OP_BIN) && nonbcd(x);
		apb(1'b1, OFF_ACC, x);
		apb(1'b1, OFF_CMD, {29'h0, o});
		apb(1'b0, OFF_ACC, 32'h0);
		case (o)
			OP_BIN: e = bcd2bin(x);
			OP_BCD: e = bin2bcd(x);
			OP_CPL: e = ~x;
			default: e = gray_exp(x[15:0]);
		endcase
		if (!bad) begin
			if (o == OP_BIN) chk(rd, e);
			if (o == OP_BCD) chk(rd, e);
			if (o == OP_CPL) chk(rd, e);
			if (o == OP_GRAY) chk(rd, e);
			chk({31'h0, zero_result_flag}, {31'h0, e == 0});
			chk({31'h0, negative_result_flag}, {31'h0, e[31]});
		end
		if (o == OP_BIN) chk({31'h0, invalid_decimal_flag}, {31'h0, bad});
	endtask

	// Parameters are placed before the command, as the program must
	task automatic tbl(input logic [2:0] o, input logic [7:0] src,
		input logic [7:0] cnt, input logic [7:0] dst);
		int n;
		apb(1'b1, OFF_STACK, {24'h0, cnt});
		apb(1'b1, OFF_ACC, {24'h0, src});
		apb(1'b1, OFF_OPND, {24'h0, dst});
		apb(1'b1, OFF_CMD, {29'h0, o});
		n = 0;
		do begin
			apb(1'b0, OFF_STATUS, 32'h0);
			n++;
		end while (rd[ST_BUSY_BIT] !== 1'b0 && n < 200);
		chk({31'h0, busy}, 32'h0);
	endtask

	task automatic run_c2h(input int cnt);
		logic [15:0] e;
		for (int i = 0; i < cnt; i++)
			mem_wr(8'(8'h10 + i), {chr(dg[2*i]), chr(dg[2*i+1])});
		tbl(OP_C2H, 8'h10, 8'(cnt), 8'h40);
		chk({31'h0, operand_overflow_flag}, 32'h0);
		for (int k = 0; k < (cnt + 1) / 2; k++) begin
			if (2 * k + 1 < cnt) e = {dg[4*k], dg[4*k+1], dg[4*k+2], dg[4*k+3]};
			else e = {8'h00, dg[4*k], dg[4*k+1]};
			mem_rd(8'(8'h40 + k));
			chk(rd, {16'h0, e});
		end
	endtask

	task automatic run_h2c(input int cnt);
		for (int i = 0; i < cnt; i++)
			mem_wr(8'(8'h20 + i), {dg[4*i], dg[4*i+1], dg[4*i+2], dg[4*i+3]});
		tbl(OP_H2C, 8'h20, 8'(cnt), 8'h80);
		for (int k = 0; k < 2 * cnt; k++) begin
			mem_rd(8'(8'h80 + k));
			chk(rd, {16'h0, chr(dg[2*k]), chr(dg[2*k+1])});
		end
	endtask

	task automatic final_report();
		$display("errors %0d comparisons %0d", n_errors, cmp_count);
		if (n_errors == 0 && cmp_count > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask

	// ****************************************
	// Main sequence and watchdog
	// ****************************************
	initial begin
		#500000;
		n_errors++;
		final_report();
	end

	initial begin
		repeat (12) @(posedge core_clk);
		rst <= 1'b0;
		@(posedge core_clk);
		chk({28'h0, invalid_decimal_flag, operand_overflow_flag,
			negative_result_flag, zero_result_flag}, 32'h0);
		acc_op(OP_BIN, 32'h9999_9999);
		acc_op(OP_BIN, 32'h0000_00A0);
		acc_op(OP_BIN, 32'h0000_0000);
		acc_op(OP_BCD, 32'hFFFF_FFFF);
		acc_op(OP_GRAY, 32'hFFFF_8000);
		acc_op(OP_GRAY, 32'h0000_0000);
		// encoder offset is left for the program to subtract
		acc_op(OP_GRAY, 32'h0000_01A4);
		acc_op(OP_CPL, 32'h0000_0000);
		for (int i = 0; i < 40; i++) begin
			v = rnd();
			op = 3'(i % 4 + 1);
			if (op == OP_BIN && i[3]) v = bin2bcd(v);
			acc_op(op, v);
		end
		// Flags left alone by ops that do not write them
		acc_op(OP_CPL, 32'hFFFF_FFFF);
		tbl(OP_C2H, 8'hF0, 8'h20, 8'h40);
		chk({31'h0, operand_overflow_flag}, 32'h1);
		chk({31'h0, zero_result_flag}, 32'h1);
		acc_op(OP_BCD, 32'h0000_0005);
		chk({31'h0, operand_overflow_flag}, 32'h1);
		tbl(OP_H2C, 8'h00, 8'h50, 8'h61);
		chk({31'h0, operand_overflow_flag}, 32'h1);
		for (int i = 0; i < 16; i++) dg[i] = 4'(i);
		run_c2h(8);
		run_h2c(4);
		for (int i = 0; i < 16; i++) begin
			v = rnd();
			dg[i] = v[3:0];
		end
		run_c2h(3);
		run_h2c(2);
		apb(1'b0, 8'h1C, 32'h0);
		chk({rd[31:1], last_err}, 32'h1);
		final_report();
	end
endmodule // ncu_top_tb
